// File: logic/tsw_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and carriers for the transmit drive and data store block
// ---------------------------------------------------------------------------
package tsw_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int HWY_N = 32;              // Transmit and receive highways
  localparam int SLOT_N = 128;            // Slots per highway at full rate
  localparam int IDX_W = 15;              // Word index width on the host bus
  localparam int FIFO_DEPTH = 8;          // Receive byte buffer depth

  // ---------------------------------------------------------------------------
  // Register word indices (byte address = 4 * index)
  // ---------------------------------------------------------------------------
  localparam logic [14:0] GEN_CMD_IDX = 15'h0000;   // General command
  localparam logic [14:0] STATUS_IDX = 15'h0001;    // Pin and buffer state
  localparam logic [14:0] FLAG_IDX = 15'h0002;      // Output active flags
  localparam logic [14:0] HWY_CFG_FIRST = 15'h0040; // Highway 0 configuration
  localparam logic [14:0] HWY_CFG_LAST = 15'h005f;  // Highway 31 configuration

  // ---------------------------------------------------------------------------
  // Data store address fields
  // ---------------------------------------------------------------------------
  localparam logic [2:0] DS_SPACE_TAG = 3'h2;       // Index bits 14..12
  localparam int DS_TAG_HI = 14;
  localparam int DS_TAG_LO = 12;
  localparam int DS_HWY_HI = 11;
  localparam int DS_HWY_LO = 7;
  localparam int DS_SLOT_HI = 6;
  localparam int DS_SLOT_LO = 0;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int GDO_BIT = 0;             // General command, global drive on
  localparam int EXT_DRV_BIT = 6;         // General command, external drivers
  localparam int HWY_DRIVE_BIT = 18;      // Highway config byte 2, bit 2
  localparam int CMD_LANE = 0;            // Byte lane of the command bits
  localparam int HWY_LANE = 2;            // Byte lane of the highway drive bit
  localparam int ST_FLOAT_BIT = 0;        // Status, float pin released
  localparam int ST_FULL_BIT = 1;         // Status, receive buffer full
  localparam logic GDO_RST = 1'h0;
  localparam logic EXT_DRV_RST = 1'h0;
  localparam logic [31:0] HWY_EN_RST = 32'h0;

  // ---------------------------------------------------------------------------
  // Bus answers and filler generator
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [31:0] FILL_SEED = 32'h0000_0001;
  localparam logic [31:0] FILL_TAPS = 32'h8020_0003;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] hwy;                      // Receive highway
    logic [6:0] slot;                     // Receive slot
    logic [7:0] data;                     // Byte, bit 7 received first
  } tsw_rx_byte_s;

  typedef struct packed {
    logic external_driver_mode;           // Fill floated slots with data
    logic global_drive_on;                // Master transmit enable
  } tsw_cmd_s;

endpackage : tsw_pkg

// File: logic/tsw_tx_drive.sv
// Notes on behaviour
// R1: Float pin low floats every output pin
// R2: Global drive on, bit 0; off forces flags 0
// R3: Per-highway drive-on bit, byte 2 bit 2
// R4: External driver bit 6 fills floated slots
// R5: Drive off, drivers off: data pins float
// R6: Drive off, drivers on: data pins carry filler
// R7: Highway off, drivers off: pin floats, flag 0
// R8: Highway off, drivers on: filler, flag 0
// R9: Highway on: slot drives 0/1 or floats
// R10: Drivers on: floated slots carry filler instead
// R11: Flag follows slot float choice per slot
// R12: Data store reads answer at once
// R13: Data store writes change nothing
// R14: Host sends bytes via substitution, not store
// R15: Store index: 010, highway, slot
// R16: Bytes kept most significant bit first
// R17: Flag high only while real data driven
`timescale 1ns/10ps

// ---------------------------------------------------------------------------
// Receive byte buffer
// ---------------------------------------------------------------------------
module tsw_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("tsw_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];    // Storage
  logic [PW-1:0] wr_q;                    // Write pointer
  logic [PW-1:0] rd_q;                    // Read pointer
  logic [PW:0] cnt_q;                     // Words held
  logic full_q;                           // Registered full
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [PW:0] cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

  assign in_ready = ~full_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
    end else begin
      wr_q <= wr_q + PW'(push);
      rd_q <= rd_q + PW'(pop);
      cnt_q <= cnt_d;
      full_q <= (cnt_d == (PW+1)'(DEPTH));
    end
  end

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : tsw_fifo

// ---------------------------------------------------------------------------
// Transmit highway drive control and data store access
// ---------------------------------------------------------------------------
module tsw_tx_drive #(
  parameter int ADDR_W = 17,
  parameter int FIFO_DEPTH = tsw_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic FLOAT_N,
  input wire logic [31:0] TX_BIT,
  input wire logic [31:0] SLOT_HIZ,
  output logic [31:0] TXD_O,
  output logic [31:0] TXD_OE,
  output logic [31:0] TX_OUTPUT_ACTIVE_FLAG_O,
  output logic [31:0] TX_OUTPUT_ACTIVE_FLAG_OE,
  input wire logic RX_VALID,
  output logic RX_READY,
  input wire tsw_pkg::tsw_rx_byte_s RX_BYTE,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  initial begin
    if (ADDR_W < tsw_pkg::IDX_W + 2) $error("tsw_tx_drive address too narrow");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic float_meta_q;                     // Float pin, first stage
  logic float_ok_q;                       // Float pin, synced; 1 = released
  tsw_pkg::tsw_cmd_s cmd_q;               // General command bits
  logic [31:0] hwy_en_q;                  // Per-highway drive on
  logic [31:0] fill_q;                    // Filler pattern generator
  logic [7:0] ds_mem [0:4095];            // Received slot bytes
  logic aw_have_q;                        // Write address held
  logic w_have_q;                         // Write data held
  logic [14:0] aw_idx_q;                  // Held write index
  logic [31:0] wdata_q;                   // Held write data
  logic [3:0] wstrb_q;                    // Held write strobes
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] txd_q;
  logic [31:0] txd_oe_q;
  logic [31:0] tx_output_active_flag_q;
  logic [31:0] tx_output_active_flag_oe_q;

  // ---------------------------------------------------------------------------
  // Float pin synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      float_meta_q <= 1'b0;
      float_ok_q <= 1'b0;
    end else begin
      float_meta_q <= FLOAT_N;
      float_ok_q <= float_meta_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Drive decisions
  // ---------------------------------------------------------------------------
  wire gdo = cmd_q.global_drive_on;
  wire ed = cmd_q.external_driver_mode;
  // Slots carrying real switched data
  wire [31:0] live = hwy_en_q & ~SLOT_HIZ & {32{gdo}};                    // see R2 see R9
  // Real data, or filler wherever external drivers are allowed
  wire [31:0] drive_d = float_ok_q ? (live | {32{ed}}) : 32'h0;           // see R1 see R4
  // Pick switched data on live slots, filler elsewhere
  wire [31:0] txd_d = (live & TX_BIT) | (~live & fill_q);                 // see R10
  // Flag marks real data only
  wire [31:0] tx_output_active_flag_d = float_ok_q ? live : 32'h0;                         // see R11 see R17
  wire [31:0] tx_output_active_flag_oe_d = {32{float_ok_q}};                               // see R1
  wire [31:0] fill_d = fill_q[0] ? ((fill_q >> 1) ^ tsw_pkg::FILL_TAPS) : (fill_q >> 1);

  // Pin registers and filler
  always_ff @(posedge CLK) begin
    if (RESET) begin
      txd_q <= 32'h0;
      txd_oe_q <= 32'h0;
      tx_output_active_flag_q <= 32'h0;
      tx_output_active_flag_oe_q <= 32'h0;
      fill_q <= tsw_pkg::FILL_SEED;
    end else begin
      txd_q <= txd_d;
      txd_oe_q <= drive_d;      // see R5 see R6 see R7 see R8
      tx_output_active_flag_q <= tx_output_active_flag_d;
      tx_output_active_flag_oe_q <= tx_output_active_flag_oe_d;
      fill_q <= fill_d;
    end
  end

  assign TXD_O = txd_q;
  assign TXD_OE = txd_oe_q;
  assign TX_OUTPUT_ACTIVE_FLAG_O = tx_output_active_flag_q;
  assign TX_OUTPUT_ACTIVE_FLAG_OE = tx_output_active_flag_oe_q;

  // ---------------------------------------------------------------------------
  // Receive buffer and data store fill
  // ---------------------------------------------------------------------------
  tsw_pkg::tsw_rx_byte_s rx_head;
  logic rx_head_valid;
  logic rx_fifo_ready;
  wire [14:0] ar_idx = ARADDR[16:2];
  wire ar_fire = ARVALID & arready_q;
  // Bits 14..12 pick the data store, then highway, then slot
  wire ar_ds = (ar_idx[tsw_pkg::DS_TAG_HI:tsw_pkg::DS_TAG_LO] == tsw_pkg::DS_SPACE_TAG); // see R15
  wire [11:0] ds_raddr = {ar_idx[tsw_pkg::DS_HWY_HI:tsw_pkg::DS_HWY_LO],
                          ar_idx[tsw_pkg::DS_SLOT_HI:tsw_pkg::DS_SLOT_LO]};
  // Single store port: a host read of the store holds off the receive fill
  wire ds_we = rx_head_valid & ~(ar_fire & ar_ds);
  wire [11:0] ds_waddr = {rx_head.hwy, rx_head.slot};

  tsw_fifo #(
    .WIDTH($bits(tsw_pkg::tsw_rx_byte_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(CLK),
    .reset(RESET),
    .in_valid(RX_VALID),
    .in_ready(rx_fifo_ready),
    .in_data(RX_BYTE),
    .out_valid(rx_head_valid),
    .out_ready(ds_we),
    .out_data(rx_head)
  );

  assign RX_READY = rx_fifo_ready;

  // Store write, only from the receive side
  always_ff @(posedge CLK) begin
    if (ds_we) begin
      ds_mem[ds_waddr] <= rx_head.data;  // see R13 see R16
    end
  end

  // ---------------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------------
  wire ar_hwy = (ar_idx >= tsw_pkg::HWY_CFG_FIRST) && (ar_idx <= tsw_pkg::HWY_CFG_LAST);
  wire [4:0] ar_hwy_n = ar_idx[4:0];
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  // Read mux
  always_comb begin
    rd_word = 32'h0;
    rd_resp = tsw_pkg::RESP_OKAY;
    if (ar_ds) begin
      rd_word = {24'h0, ds_mem[ds_raddr]};    // see R12 see R16
    end else if (ar_idx == tsw_pkg::GEN_CMD_IDX) begin
      rd_word[tsw_pkg::GDO_BIT] = cmd_q.global_drive_on;
      rd_word[tsw_pkg::EXT_DRV_BIT] = cmd_q.external_driver_mode;
    end else if (ar_idx == tsw_pkg::STATUS_IDX) begin
      rd_word[tsw_pkg::ST_FLOAT_BIT] = float_ok_q;
      rd_word[tsw_pkg::ST_FULL_BIT] = ~rx_fifo_ready;
    end else if (ar_idx == tsw_pkg::FLAG_IDX) begin
      rd_word = tx_output_active_flag_q;
    end else if (ar_hwy) begin
      rd_word[tsw_pkg::HWY_DRIVE_BIT] = hwy_en_q[ar_hwy_n];
    end else begin
      rd_resp = tsw_pkg::RESP_DECERR;
    end
  end

  // Read channel: answer on the edge after the address is taken
  always_ff @(posedge CLK) begin
    if (RESET) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= tsw_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;                       // see R12
      rdata_q <= rd_word;
      rresp_q <= rd_resp;
    end else if (rvalid_q && RREADY) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  // ---------------------------------------------------------------------------
  // Write channels
  // ---------------------------------------------------------------------------
  wire aw_fire = AWVALID & ~aw_have_q;
  wire w_fire = WVALID & ~w_have_q;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_done = bvalid_q & BREADY;
  wire wr_cmd = (aw_idx_q == tsw_pkg::GEN_CMD_IDX);
  wire wr_hwy = (aw_idx_q >= tsw_pkg::HWY_CFG_FIRST) && (aw_idx_q <= tsw_pkg::HWY_CFG_LAST);
  // Store space and read-only words accept and ignore writes
  wire wr_quiet = (aw_idx_q[tsw_pkg::DS_TAG_HI:tsw_pkg::DS_TAG_LO] == tsw_pkg::DS_SPACE_TAG)
                  || (aw_idx_q == tsw_pkg::STATUS_IDX) || (aw_idx_q == tsw_pkg::FLAG_IDX); // see R13
  wire [1:0] wr_resp = (wr_cmd || wr_hwy || wr_quiet) ? tsw_pkg::RESP_OKAY : tsw_pkg::RESP_DECERR;
  wire [4:0] wr_hwy_n = aw_idx_q[4:0];

  // Address and data holding
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 15'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= AWADDR[16:2];
      end else if (wr_done) begin
        aw_have_q <= 1'b0;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end else if (wr_done) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Response
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bvalid_q <= 1'b0;
      bresp_q <= tsw_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_resp;
    end else if (wr_done) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cmd_q.global_drive_on <= tsw_pkg::GDO_RST;
      cmd_q.external_driver_mode <= tsw_pkg::EXT_DRV_RST;
      hwy_en_q <= tsw_pkg::HWY_EN_RST;
    end else if (wr_go) begin
      if (wr_cmd && wstrb_q[tsw_pkg::CMD_LANE]) begin
        cmd_q.global_drive_on <= wdata_q[tsw_pkg::GDO_BIT];          // see R2
        cmd_q.external_driver_mode <= wdata_q[tsw_pkg::EXT_DRV_BIT]; // see R4
      end
      if (wr_hwy && wstrb_q[tsw_pkg::HWY_LANE]) begin
        hwy_en_q[wr_hwy_n] <= wdata_q[tsw_pkg::HWY_DRIVE_BIT];       // see R3
      end
    end
  end

  assign AWREADY = ~aw_have_q;
  assign WREADY = ~w_have_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_float_all_hiz: assert property ( // see R1
    !float_ok_q |=> (TXD_OE == 32'h0) && (TX_OUTPUT_ACTIVE_FLAG_OE == 32'h0))
    else $error("pins driven while float pin low");
  chk_gdo_flags_low: assert property ( // see R2
    float_ok_q && !gdo |=> (TX_OUTPUT_ACTIVE_FLAG_O == 32'h0) && (TX_OUTPUT_ACTIVE_FLAG_OE == 32'hffff_ffff))
    else $error("flag high with global drive off");
  chk_hwy_bit_write: assert property ( // see R3
    wr_go && wr_hwy && wstrb_q[2] |=> hwy_en_q[$past(wr_hwy_n)] == $past(wdata_q[18]))
    else $error("highway drive bit not taken from byte 2 bit 2");
  chk_ext_off_float: assert property ( // see R5
    float_ok_q && !gdo && !ed |=> TXD_OE == 32'h0)
    else $error("data pins driven with drivers off");
  chk_ext_on_fill: assert property ( // see R6
    float_ok_q && !gdo && ed |=> TXD_OE == 32'hffff_ffff)
    else $error("data pins not driven with external drivers");
  chk_hwy_off_pins: assert property ( // see R7 see R8
    float_ok_q && gdo |=> ((TX_OUTPUT_ACTIVE_FLAG_O & ~$past(hwy_en_q)) == 32'h0)
      && (((TXD_OE ^ {32{$past(ed)}}) & ~$past(hwy_en_q)) == 32'h0))
    else $error("disabled highway pin state wrong");
  chk_slot_flag: assert property ( // see R11 see R17
    float_ok_q && gdo |=> TX_OUTPUT_ACTIVE_FLAG_O == $past(hwy_en_q & ~SLOT_HIZ))
    else $error("flag does not follow slot float choice");
  chk_slot_drive: assert property ( // see R9 see R10
    float_ok_q && gdo |=> (TXD_OE == ($past(hwy_en_q & ~SLOT_HIZ) | {32{$past(ed)}}))
      && ((TXD_O & TX_OUTPUT_ACTIVE_FLAG_O) == ($past(TX_BIT) & TX_OUTPUT_ACTIVE_FLAG_O)))
    else $error("slot data or drive wrong");
  chk_ds_read_next: assert property ( // see R12
    ar_fire && ar_ds |=> RVALID && (RRESP == 2'h0) && (RDATA[31:8] == 24'h0))
    else $error("store read not answered next cycle");
  chk_ds_write_src: assert property ( // see R13
    wr_go && (aw_idx_q[14:12] == tsw_pkg::DS_SPACE_TAG) && !ds_we
      |=> ds_mem[$past(aw_idx_q[11:0])] == $past(ds_mem[aw_idx_q[11:0]]))
    else $error("host write changed the store");

  cov_ds_read: cover property (ar_fire && ar_ds ##1 RVALID);
  cov_float_release: cover property (!float_ok_q ##1 float_ok_q);
  cov_fill_slot: cover property (float_ok_q && gdo && ed && (SLOT_HIZ != 32'h0));
  cov_fifo_full: cover property (!RX_READY);

endmodule : tsw_tx_drive

// File: sim/tsw_rx_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Far-side receive highway source, queued bytes, optional stalls
// ---------------------------------------------------------------------------
module tsw_rx_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  output logic rx_valid,
  input wire logic rx_ready,
  output tsw_pkg::tsw_rx_byte_s rx_byte
);
  tsw_pkg::tsw_rx_byte_s q[$]; // Bytes waiting to go out
  logic gap_q; // Stall phase while slow
  // Offer the head byte and hold it until taken; idle data is the inverse of the last
  always @(posedge clk) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_byte <= '0;
      gap_q <= 1'b0;
    end else begin
      gap_q <= ~gap_q;
      if (!rx_valid || rx_ready) begin
        if (rx_valid) void'(q.pop_front());
        if (q.size() > 0 && !(slow && gap_q)) begin
          rx_valid <= 1'b1;
          rx_byte <= q[0];
        end else begin
          rx_valid <= 1'b0;
          rx_byte <= ~rx_byte;
        end
      end
    end
  end
endmodule : tsw_rx_model

// File: sim/tb_top.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Bench for transmit drive control and data store reads
// ---------------------------------------------------------------------------
module tb_top;
  logic CLK = 0, RESET = 1, FLOAT_N = 1, slow = 0;
  logic [31:0] TX_BIT = '0, SLOT_HIZ = '0, WDATA = '0, TXD_O, TXD_OE, TX_OUTPUT_ACTIVE_FLAG_O, TX_OUTPUT_ACTIVE_FLAG_OE, RDATA;
  logic [16:0] AWADDR = '0, ARADDR = '0;
  logic [3:0] WSTRB = '0;
  logic [1:0] BRESP, RRESP;
  logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic RX_VALID, RX_READY, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  tsw_pkg::tsw_rx_byte_s RX_BYTE;
  int fails = 0, comparisons = 0, cyc = 0;
  logic [33:0] rd_q[$]; // Expected {resp, data} of each read
  logic [31:0] seed = 32'd31889, en, live;
  logic [7:0] sb[12]; // Bytes sent to the store
  tsw_tx_drive dut (.CLK(CLK), .RESET(RESET), .FLOAT_N(FLOAT_N), .TX_BIT(TX_BIT),
    .SLOT_HIZ(SLOT_HIZ), .TXD_O(TXD_O), .TXD_OE(TXD_OE), .TX_OUTPUT_ACTIVE_FLAG_O(TX_OUTPUT_ACTIVE_FLAG_O), .TX_OUTPUT_ACTIVE_FLAG_OE(TX_OUTPUT_ACTIVE_FLAG_OE),
    .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_BYTE(RX_BYTE), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY));
  tsw_rx_model p (.clk(CLK), .reset(RESET), .slow(slow), .rx_valid(RX_VALID),
    .rx_ready(RX_READY), .rx_byte(RX_BYTE));
  // ---------------------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------------------
  initial begin
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [16:0] ba(input logic [14:0] idx);
    return {idx, 2'b00};
  endfunction : ba
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    chk({2'b00, got}, {2'b00, exp});
  endtask : chk_pin
  // ---------------------------------------------------------------------------
  // Bus master tasks
  // ---------------------------------------------------------------------------
  task automatic axi_wr(input logic [16:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit aw, w, b;
    @(posedge CLK);
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= d;
    WSTRB <= s;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    aw = 0;
    w = 0;
    b = 0;
    while (!b) begin
      @(posedge CLK);
      if (aw && w && BVALID) begin
        b = 1;
        BREADY <= 1'b0;
        chk({BRESP, 32'h0}, {er, 32'h0});
      end
      if (!aw && AWREADY) begin
        aw = 1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY) begin
        w = 1;
        WVALID <= 1'b0;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [16:0] a, input logic [33:0] exp);
    bit ar, r;
    @(posedge CLK);
    rd_q.push_back(exp);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    ar = 0;
    r = 0;
    while (!r) begin
      @(posedge CLK);
      if (ar && RVALID) begin
        r = 1;
        RREADY <= 1'b0;
      end else if (!ar && ARREADY) begin
        ar = 1;
        ARVALID <= 1'b0;
      end
    end
  endtask : axi_rd
  // Read answers are compared against the oldest note
  always @(posedge CLK) begin
    if (RVALID && RREADY) chk({RRESP, RDATA}, rd_q.pop_front());
  end
  // Drive one random slot and check the pins an edge later
  task automatic pin_step(input logic gdo, input logic ed);
    logic [31:0] hz, tb;
    @(posedge CLK);
    hz = xs();
    tb = xs();
    SLOT_HIZ <= hz;
    TX_BIT <= tb;
    live = gdo ? (en & ~hz) : 32'h0;
    @(posedge CLK);
    #1;
    chk_pin(TXD_OE, live | {32{ed}});
    chk_pin(TX_OUTPUT_ACTIVE_FLAG_O, live);
    chk_pin(TXD_O & live, tb & live);
    chk_pin(TX_OUTPUT_ACTIVE_FLAG_OE, 32'hffff_ffff);
  endtask : pin_step
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    axi_rd(ba(tsw_pkg::GEN_CMD_IDX), {tsw_pkg::RESP_OKAY, 32'h0});
    axi_rd(ba(tsw_pkg::STATUS_IDX), {tsw_pkg::RESP_OKAY, 32'h1});
    axi_rd(ba(15'h0003), {tsw_pkg::RESP_DECERR, 32'h0});
    // Float pin low releases every pin
    FLOAT_N <= 1'b0;
    repeat (4) @(posedge CLK);
    #1;
    chk_pin(TXD_OE | TX_OUTPUT_ACTIVE_FLAG_OE | TX_OUTPUT_ACTIVE_FLAG_O, 32'h0);
    axi_rd(ba(tsw_pkg::STATUS_IDX), {tsw_pkg::RESP_OKAY, 32'h0});
    FLOAT_N <= 1'b1;
    // Random per-highway drive enables on byte lane 2
    en = xs();
    for (int i = 0; i < 32; i++) begin
      axi_wr(ba(tsw_pkg::HWY_CFG_FIRST + 15'(i)), 32'(en[i]) << 18, 4'h4, 2'h0);
    end
    // Every global drive and external driver combination
    for (int k = 0; k < 4; k++) begin
      axi_wr(ba(tsw_pkg::GEN_CMD_IDX), {25'h0, k[1], 5'h0, k[0]}, 4'h1, 2'h0);
      axi_rd(ba(tsw_pkg::GEN_CMD_IDX), {2'b00, 25'h0, k[1], 5'h0, k[0]});
      repeat (8) pin_step(k[0], k[1]);
    end
    axi_wr(ba(15'h0003), 32'h0, 4'hf, tsw_pkg::RESP_DECERR);
    // Received bytes reach the store, read back most significant bit intact, source stalling
    slow <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      sb[i] = xs();
      p.q.push_back({5'(i), 7'(3 * i + 1), sb[i]});
    end
    for (int n = 0; n < 200 && (p.q.size() > 0 || RX_VALID); n++) @(posedge CLK);
    repeat (4) @(posedge CLK);
    for (int i = 0; i < 12; i++) begin
      axi_rd(ba({3'h2, 5'(i), 7'(3 * i + 1)}), {2'b00, 24'h0, sb[i]});
    end
    // Host writes leave the store alone; own bytes go by substitution instead
    axi_wr(ba({3'h2, 5'd0, 7'd1}), 32'h0000_00ff ^ 32'(sb[0]), 4'hf, 2'h0);
    axi_rd(ba({3'h2, 5'd0, 7'd1}), {2'b00, 24'h0, sb[0]});
    repeat (4) @(posedge CLK);
    report_and_stop();
  end
endmodule : tb_top
